// ==== rtl/simd_lane_pkg.sv ====
package simd_lane_pkg;

    // Register array geometry
    localparam int DW       = 32;
    localparam int ELEMS    = 8;
    localparam int REG_BITS = 256;
    localparam int RIDX_W   = 7;
    localparam int NUM_REGS = 128;
    localparam int WIN_BITS = 2 * REG_BITS;
    localparam int EMASK_W  = 16;

    // Bus register offsets
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_INSN     = 8'h04;
    localparam logic [7:0] OFF_OPND     = 8'h08;
    localparam logic [7:0] OFF_EMASK    = 8'h0C;
    localparam logic [7:0] OFF_STAT     = 8'h10;
    localparam logic [7:0] OFF_ARR_ADDR = 8'h14;
    localparam logic [7:0] OFF_ARR_DATA = 8'h18;

    // Bit positions
    localparam int CTRL_GO_BIT     = 0;
    localparam int STAT_BUSY_BIT   = 1 - 1;
    localparam int STAT_BRANCH_BIT = 1;

    // Reset values
    localparam logic [31:0]        INSN_RST  = 32'h00000000;
    localparam logic [31:0]        OPND_RST  = 32'h00000000;
    localparam logic [EMASK_W-1:0] EMASK_RST = 16'h0000;

    typedef enum logic [1:0] {
        OP_MOV   = 2'b00,
        OP_ADD_D = 2'b01,
        OP_ADD_W = 2'b10,
        OP_AND   = 2'b11
    } op_t;

    typedef enum logic [2:0] {
        ES_1  = 3'b000,
        ES_2  = 3'b001,
        ES_4  = 3'b010,
        ES_8  = 3'b011,
        ES_16 = 3'b100
    } esize_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_FETCH = 3'b001,
        ST_EX_LO = 3'b010,
        ST_EX_HI = 3'b011,
        ST_WB    = 3'b100
    } lane_state_t;

    // Instruction word, bit 0 is op[0]
    typedef struct packed {
        logic [1:0] spare;
        logic [7:0] swz1;
        logic [7:0] swz0;
        logic [3:0] dmask;
        logic       vs_zero1;
        logic       vs_zero0;
        logic       compressed;
        logic       mask_bypass_option;
        logic       four_lane_vector_access;
        esize_t     esize;
        op_t        op;
    } insn_t;

    // Operand word, bit 0 is dst[0]
    typedef struct packed {
        logic [4:0]        spare;
        logic [2:0]        sub1;
        logic [2:0]        sub0;
        logic [RIDX_W-1:0] src1;
        logic [RIDX_W-1:0] src0;
        logic [RIDX_W-1:0] dst;
    } opnd_t;

    typedef struct packed {
        logic               load;
        logic [EMASK_W-1:0] mask;
    } dispatch_t;

    typedef struct packed {
        logic              en;
        logic [RIDX_W-1:0] addr;
    } arr_rd_t;

    typedef struct packed {
        logic [ELEMS-1:0]    we;
        logic [RIDX_W-1:0]   addr;
        logic [REG_BITS-1:0] data;
    } arr_wr_t;

endpackage

// ==== rtl/general_register_array.sv ====
`timescale 1ns/1ns
`default_nettype none

module general_register_array
    import simd_lane_pkg::*;
#(
    parameter int DEPTH = NUM_REGS
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_n_i,
    input  wire arr_rd_t       rd_i,
    input  wire arr_wr_t       wr_i,
    output logic [REG_BITS-1:0] rd_data_o
);

    typedef struct packed {
        logic [DEPTH-1:0][REG_BITS-1:0] mem;
        logic [REG_BITS-1:0]            rd;
    } arr_state_t;

    arr_state_t st_reg;
    arr_state_t st_next;

    if (DEPTH < 2 || DEPTH > 2**RIDX_W) begin : g_bad_depth
        $error("DEPTH out of range");
    end

    // Registered read; per element write strobes
    always_comb begin
        st_next = st_reg;
        if (rd_i.en) begin
            st_next.rd = (int'(rd_i.addr) < DEPTH) ? st_reg.mem[rd_i.addr] : '0;
        end
        for (int e = 0; e < ELEMS; e++) begin
            if (wr_i.we[e] && int'(wr_i.addr) < DEPTH) begin
                st_next.mem[wr_i.addr][e*DW +: DW] = wr_i.data[e*DW +: DW];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o = st_reg.rd;

endmodule

`default_nettype wire

// ==== rtl/simd_lane_operand_datapath.sv ====
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// Function
// - Register entry is 256 bits, eight elements
// - Execution size sets number of lanes
// - Lanes beyond execution size stay unmodified
// - Component mask blocks writes of masked elements in four-lane mode
// - Mask bypass ignores execution mask entirely
// - Swizzle routes any source component anywhere in its vector, in four-lane mode only
// - Four-lane instruction still takes two cycles
// - Execution mask from dispatch mask gates lanes
// - Vector sources may sit at 16-byte positions
// - Zero vertical stride replicates one vector
// - Paired mode holds two vectors per register
// - Channel-serial mode runs eight flows
// - Compressed mode spans two adjacent registers
// - Same-register sources split by subregister
// - Single-flow branch uses one scalar condition
// - Opcode selects the arithmetic data type
// - Compressed runs as two eight-lane halves
// - Sources two registers, destination one
module simd_lane_operand_datapath
    import simd_lane_pkg::*;
(
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             hsel_i,
    input  wire logic [31:0]      haddr_i,
    input  wire logic [1:0]       htrans_i,
    input  wire logic             hwrite_i,
    input  wire logic [2:0]       hsize_i,
    input  wire logic [31:0]      hwdata_i,
    input  wire logic             hready_i,
    output logic      [31:0]      hrdata_o,
    output logic                  hreadyout_o,
    output logic                  hresp_o,
    input  wire dispatch_t        dispatch_i,
    output logic                  busy_o,
    output logic                  branch_flag_o
);

    typedef struct packed {
        lane_state_t          state;
        insn_t                insn;
        opnd_t                opnd;
        logic [EMASK_W-1:0]   emask;
        logic                 branch;
        logic                 wr_pend;
        logic [7:0]           wr_addr;
        logic [31:0]          rdata;
        logic [RIDX_W+2:0]    arr_addr;
        logic                 arr_pend;
        logic [31:0]          arr_cap;
        logic [2:0]           fetch_k;
        logic                 pass;
        logic [WIN_BITS-1:0]  win0;
        logic [WIN_BITS-1:0]  win1;
        logic [REG_BITS-1:0]  result;
        logic [ELEMS-1:0]     wen;
    } core_state_t;

    core_state_t st;
    core_state_t nx;

    arr_rd_t              rd;
    arr_wr_t              wr;
    logic [REG_BITS-1:0]  rd_data;
    logic [ELEMS-1:0][DW-1:0] lane_val;
    logic [ELEMS-1:0]     lane_en;
    logic [ELEMS-1:0]     size_ok;
    logic [ELEMS-1:0]     emask_ok;
    logic [4:0]           size_n;
    logic [31:0]          stat_word;

    // Lane count of the execution size
    function automatic logic [4:0] esize_lanes(input esize_t es);
        unique case (es)
            ES_1:    esize_lanes = 5'h01;
            ES_2:    esize_lanes = 5'h02;
            ES_4:    esize_lanes = 5'h04;
            ES_8:    esize_lanes = 5'h08;
            ES_16:   esize_lanes = 5'h10;
            default: esize_lanes = 5'h00;
        endcase
    endfunction

    // Window element feeding a lane
    function automatic logic [3:0] src_idx(
        input logic       four_lane,
        input logic       vs_zero,
        input logic [2:0] sub,
        input logic [7:0] swz,
        input logic [2:0] lane
    );
        logic [3:0] base;
        if (four_lane) begin
            // Sixteen-byte position, vector per flow
            base = {1'b0, sub[2], 2'b00} + (vs_zero ? 4'h0 : {1'b0, lane[2], 2'b00});
            src_idx = base + {2'b00, swz[{lane[1:0], 1'b0} +: 2]};
        end else begin
            // One component of eight flows per register
            src_idx = {1'b0, sub} + (vs_zero ? 4'h0 : {1'b0, lane});
        end
    endfunction

    // Element from a two-register window
    function automatic logic [DW-1:0] pick(input logic [WIN_BITS-1:0] win, input logic [3:0] idx);
        pick = win[int'(idx) * DW +: DW];
    endfunction

    // Operation and data type from the opcode
    function automatic logic [DW-1:0] alu(input op_t op, input logic [DW-1:0] a, input logic [DW-1:0] b);
        unique case (op)
            OP_MOV:   alu = a;
            OP_ADD_D: alu = a + b;
            OP_ADD_W: alu = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
            OP_AND:   alu = a & b;
        endcase
    endfunction

    assign size_n = esize_lanes(st.insn.esize);

    // Parallel lanes and their write enables
    for (genvar i = 0; i < ELEMS; i++) begin : g_lane
        localparam logic [2:0] LANE = 3'(i);
        logic [4:0] glane;
        logic [3:0] idx0;
        logic [3:0] idx1;
        assign glane = {1'b0, st.pass, LANE};
        assign idx0 = src_idx(st.insn.four_lane_vector_access, st.insn.vs_zero0, st.opnd.sub0, st.insn.swz0, LANE);
        assign idx1 = src_idx(st.insn.four_lane_vector_access, st.insn.vs_zero1, st.opnd.sub1, st.insn.swz1, LANE);
        assign lane_val[i] = alu(st.insn.op, pick(st.win0, idx0), pick(st.win1, idx1));
        assign size_ok[i] = glane < size_n;
        assign emask_ok[i] = st.emask[glane[3:0]];
        // Size, component and execution mask terms
        assign lane_en[i] = size_ok[i]
            & (!st.insn.four_lane_vector_access | st.insn.dmask[LANE[1:0]])
            & (st.insn.mask_bypass_option | emask_ok[i]);
    end

    // Status word
    always_comb begin
        stat_word = '0;
        stat_word[STAT_BUSY_BIT] = (st.state != ST_IDLE);
        stat_word[STAT_BRANCH_BIT] = st.branch;
    end

    // Next state: bus, dispatch, sequencer
    always_comb begin
        nx = st;
        rd = '0;
        wr = '0;

        // Array backdoor read capture
        nx.arr_pend = 1'b0;
        if (st.arr_pend) begin
            nx.arr_cap = rd_data[int'(st.arr_addr[2:0]) * DW +: DW];
        end

        // Bus data phase writes, only while idle
        if (st.wr_pend && st.state == ST_IDLE) begin
            case (st.wr_addr)
                OFF_CTRL: begin
                    if (hwdata_i[CTRL_GO_BIT]) begin
                        nx.state = ST_FETCH;
                        nx.fetch_k = 3'h0;
                        nx.pass = 1'b0;
                    end
                end
                OFF_INSN: nx.insn = insn_t'(hwdata_i);
                OFF_OPND: nx.opnd = opnd_t'(hwdata_i);
                OFF_ARR_ADDR: begin
                    nx.arr_addr = hwdata_i[RIDX_W+2:0];
                    nx.arr_pend = 1'b1;
                    rd.en = 1'b1;
                    rd.addr = hwdata_i[RIDX_W+2:3];
                end
                OFF_ARR_DATA: begin
                    wr.we[st.arr_addr[2:0]] = 1'b1;
                    wr.addr = st.arr_addr[RIDX_W+2:3];
                    wr.data = {ELEMS{hwdata_i}};
                end
                default: ;
            endcase
        end

        // Bus address phase
        nx.wr_pend = 1'b0;
        if (hsel_i && htrans_i[1] && hready_i) begin
            if (hwrite_i) begin
                nx.wr_pend = 1'b1;
                nx.wr_addr = haddr_i[7:0];
            end else begin
                case (haddr_i[7:0])
                    OFF_INSN:     nx.rdata = st.insn;
                    OFF_OPND:     nx.rdata = st.opnd;
                    OFF_EMASK:    nx.rdata = {16'h0000, st.emask};
                    OFF_STAT:     nx.rdata = stat_word;
                    OFF_ARR_ADDR: nx.rdata = {22'h0, st.arr_addr};
                    OFF_ARR_DATA: nx.rdata = st.arr_cap;
                    default:      nx.rdata = 32'h00000000;
                endcase
            end
        end

        // Execution mask from the dispatcher
        if (dispatch_i.load) begin
            nx.emask = dispatch_i.mask;
        end

        unique case (st.state)
            ST_IDLE: ;
            ST_FETCH: begin
                // Two adjacent registers per source
                if (st.fetch_k < 3'h4) begin
                    rd.en = 1'b1;
                    rd.addr = (st.fetch_k[1] ? st.opnd.src1 : st.opnd.src0)
                              + RIDX_W'(st.pass) + RIDX_W'(st.fetch_k[0]);
                end
                // Each source read on its own
                unique case (st.fetch_k)
                    3'h1: nx.win0[REG_BITS-1:0] = rd_data;
                    3'h2: nx.win0[WIN_BITS-1:REG_BITS] = rd_data;
                    3'h3: nx.win1[REG_BITS-1:0] = rd_data;
                    3'h4: nx.win1[WIN_BITS-1:REG_BITS] = rd_data;
                    default: ;
                endcase
                nx.fetch_k = st.fetch_k + 3'h1;
                if (st.fetch_k == 3'h4) begin
                    nx.state = ST_EX_LO;
                end
            end
            ST_EX_LO, ST_EX_HI: begin
                // Four adders per cycle, halves in turn
                for (int i = 0; i < ELEMS; i++) begin
                    if ((i >= ELEMS / 2) == (st.state == ST_EX_HI)) begin
                        nx.result[i*DW +: DW] = lane_val[i];
                        nx.wen[i] = lane_en[i];
                    end
                end
                nx.state = (st.state == ST_EX_LO) ? ST_EX_HI : ST_WB;
            end
            ST_WB: begin
                // Disabled elements are never strobed
                wr.we = st.wen;
                wr.addr = st.opnd.dst + RIDX_W'(st.pass);
                wr.data = st.result;
                if (!st.pass) begin
                    nx.branch = st.wen[0] & (|st.result[DW-1:0]);
                end
                if (st.insn.compressed && !st.pass) begin
                    nx.state = ST_FETCH;
                    nx.fetch_k = 3'h0;
                    nx.pass = 1'b1;
                end else begin
                    nx.state = ST_IDLE;
                end
            end
            default: nx.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
            st.state <= ST_IDLE;
            st.insn <= insn_t'(INSN_RST);
            st.opnd <= opnd_t'(OPND_RST);
            st.emask <= EMASK_RST;
        end else begin
            st <= nx;
        end
    end

    general_register_array #(
        .DEPTH      (NUM_REGS)
    ) u_array (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rd_i       (rd),
        .wr_i       (wr),
        .rd_data_o  (rd_data)
    );

    assign hrdata_o = st.rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign busy_o = (st.state != ST_IDLE);
    assign branch_flag_o = st.branch;

    // Checks on the sequencer and write strobes
    default clocking dclk @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_size_gate;
        (st.state == ST_WB) |-> ((st.wen & ~size_ok) == '0);
    endproperty
    a_size_gate: assert property (p_size_gate)
        else $error("Lane beyond execution size written");

    property p_dmask_gate;
        (st.state == ST_WB && st.insn.four_lane_vector_access)
            |-> ((st.wen & ~{2{st.insn.dmask}}) == '0);
    endproperty
    a_dmask_gate: assert property (p_dmask_gate)
        else $error("Masked component written");

    property p_bypass_all;
        (st.state == ST_WB && st.insn.mask_bypass_option && !st.insn.four_lane_vector_access)
            |-> (st.wen == size_ok);
    endproperty
    a_bypass_all: assert property (p_bypass_all)
        else $error("Mask bypass did not enable all lanes");

    property p_emask_gate;
        (st.state == ST_WB && !st.insn.mask_bypass_option
            && !$past(dispatch_i.load) && !$past(dispatch_i.load, 2))
            |-> ((st.wen & ~emask_ok) == '0);
    endproperty
    a_emask_gate: assert property (p_emask_gate)
        else $error("Lane written despite execution mask");

    property p_two_cycle;
        (st.state == ST_EX_LO) |=> (st.state == ST_EX_HI) ##1 (st.state == ST_WB);
    endproperty
    a_two_cycle: assert property (p_two_cycle)
        else $error("Execution did not take two cycles");

    property p_fetch_len;
        (st.state == ST_FETCH && st.fetch_k == 3'h0) |-> ##5 (st.state == ST_EX_LO);
    endproperty
    a_fetch_len: assert property (p_fetch_len)
        else $error("Operand fetch length wrong");

    property p_second_half;
        (st.state == ST_WB && st.insn.compressed && !st.pass)
            |=> (st.state == ST_FETCH && st.pass);
    endproperty
    a_second_half: assert property (p_second_half)
        else $error("Compressed second half not started");

    property p_dispatch_load;
        dispatch_i.load |=> (st.emask == $past(dispatch_i.mask));
    endproperty
    a_dispatch_load: assert property (p_dispatch_load)
        else $error("Execution mask not loaded from dispatch");

endmodule

`default_nettype wire

// ==== testbench/dispatch_model.sv ====
`timescale 1ns/1ns
`default_nettype none

// Dispatch side: hands a per-thread mask to the datapath
module dispatch_model
    import simd_lane_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       go_i,
    input  wire logic [1:0] flows_i,
    input  wire logic [3:0] span_ok_i,
    output var dispatch_t   dispatch_o
);
    // One load pulse; mask scrambled while not loading
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            dispatch_o <= '0;
        end else if (go_i) begin
            dispatch_o.load <= 1'b1;
            case (flows_i)
                2'd0:    dispatch_o.mask <= 16'h000F;
                2'd1:    dispatch_o.mask <= 16'h00FF;
                default: dispatch_o.mask <= {{4{span_ok_i[3]}}, {4{span_ok_i[2]}},
                                             {4{span_ok_i[1]}}, {4{span_ok_i[0]}}};
            endcase
        end else begin
            dispatch_o.load <= 1'b0;
            dispatch_o.mask <= ~dispatch_o.mask;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/simd_lane_operand_datapath_bench.sv ====
`timescale 1ns/1ns
`default_nettype none

module simd_lane_operand_datapath_bench
    import simd_lane_pkg::*;
;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        hsel     = 1'b0;
    logic [31:0] haddr    = 32'h00000000;
    logic [1:0]  htrans   = 2'b00;
    logic        hwrite   = 1'b0;
    logic [31:0] hwdata   = 32'h00000000;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        busy;
    logic        branch;
    logic        go       = 1'b0;
    logic [1:0]  flows    = 2'b00;
    logic [3:0]  span_ok  = 4'h0;
    dispatch_t   disp_bus;
    logic [31:0] sh [0:NUM_REGS-1][0:ELEMS-1];
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #10 core_clk = ~core_clk;

    simd_lane_operand_datapath u_dut (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
        .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
        .dispatch_i(disp_bus), .busy_o(busy), .branch_flag_o(branch)
    );

    dispatch_model u_disp (
        .core_clk_i(core_clk), .rst_n_i(rst_n), .go_i(go), .flows_i(flows),
        .span_ok_i(span_ok), .dispatch_o(disp_bus)
    );

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask

    // Single AHB-Lite transfer, entered and left just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        q = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic fill(input int rg, input logic [31:0] base);
        logic [31:0] q;
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, OFF_ARR_ADDR, rg * 8 + d, q);
            bus(1'b1, OFF_ARR_DATA, base + d, q);
            sh[rg][d] = base + d;
        end
    endtask

    task automatic chkreg(input int rg);
        logic [31:0] q;
        for (int d = 0; d < 8; d++) begin
            bus(1'b1, OFF_ARR_ADDR, rg * 8 + d, q);
            repeat (2) @(posedge core_clk);
            bus(1'b0, OFF_ARR_DATA, 32'h0, q);
            chk("array dword", q, sh[rg][d]);
        end
    endtask

    task automatic disp(input logic [1:0] f, input logic [3:0] ok);
        flows <= f;
        span_ok <= ok;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    function automatic insn_t mk(op_t op, esize_t es, logic fl, logic byp, logic cmp, logic vs0,
                                 logic [3:0] dm, logic [7:0] s0, logic [7:0] s1);
        return {2'b00, s1, s0, dm, 1'b0, vs0, cmp, byp, fl, es, op};
    endfunction

    function automatic opnd_t mo(logic [6:0] d, logic [6:0] a, logic [6:0] b, logic [2:0] u0, logic [2:0] u1);
        return {5'h00, u1, u0, b, a, d};
    endfunction

    // Source element from the two-register window
    function automatic logic [31:0] src(int rg, logic [2:0] s, logic [7:0] z, logic vs, logic fl, int l);
        int x;
        x = fl ? 4 * s[2] + (vs ? 0 : 4 * (l / 4)) + z[2 * (l % 4) +: 2] : s + (vs ? 0 : l);
        return sh[rg + x / 8][x % 8];
    endfunction

    // Issue one instruction, predict lanes, then compare destination and its neighbour
    task automatic run(input insn_t i, input opnd_t o, input logic [15:0] em);
        logic [31:0] q, a, b, r;
        logic        br, en;
        int          n, ch;
        bus(1'b1, OFF_INSN, i, q);
        bus(1'b1, OFF_OPND, o, q);
        bus(1'b1, OFF_CTRL, 32'h1, q);
        n = 0;
        while (busy !== 1'b1 && n < 3) begin n++; @(posedge core_clk); end
        n = 0;
        while (busy === 1'b1 && n < 40) begin n++; @(posedge core_clk); end
        chk("busy cycles", n, i.compressed ? 16 : 8);
        br = 1'b0;
        for (int p = 0; p <= int'(i.compressed); p++) begin
            for (int l = 0; l < 8; l++) begin
                ch = p * 8 + l;
                en = (ch < (1 << i.esize)) && (!i.four_lane_vector_access || i.dmask[l % 4])
                     && (i.mask_bypass_option || em[ch]);
                a = src(o.src0 + p, o.sub0, i.swz0, i.vs_zero0, i.four_lane_vector_access, l);
                b = src(o.src1 + p, o.sub1, i.swz1, i.vs_zero1, i.four_lane_vector_access, l);
                case (i.op)
                    OP_MOV:   r = a;
                    OP_ADD_D: r = a + b;
                    OP_ADD_W: r = {a[31:16] + b[31:16], a[15:0] + b[15:0]};
                    default:  r = a & b;
                endcase
                if (en) sh[o.dst + p][l] = r;
                if (ch == 0) br = en && (r != 32'h0);
            end
        end
        chk("branch flag", {31'h0, branch}, {31'h0, br});
        chkreg(o.dst);
        chkreg(o.dst + 1);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        bus(1'b0, OFF_INSN, 32'h0, q);
        chk("insn reset", q, INSN_RST);
        bus(1'b0, OFF_OPND, 32'h0, q);
        chk("opnd reset", q, OPND_RST);
        bus(1'b0, OFF_EMASK, 32'h0, q);
        chk("emask reset", q, {16'h0000, EMASK_RST});
        bus(1'b1, 8'h40, 32'h5A5A5A5A, q);
        bus(1'b0, 8'h40, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(1'b0, OFF_STAT, 32'h0, q);
        chk("stat idle", q, 32'h0);
    endtask

    task automatic t_simd4();
        fill(2, 32'h00001000);
        fill(3, 32'hA0A00000);
        fill(4, 32'hB0B00000);
        run(mk(OP_ADD_D, ES_4, 1, 1, 0, 0, 4'b0111, 8'h39, 8'h4E), mo(3, 2, 2, 0, 4), 16'h0000);
        run(mk(OP_ADD_D, ES_4, 1, 0, 0, 0, 4'hF, 8'hE4, 8'hE4), mo(3, 2, 2, 0, 4), 16'h0000);
    endtask

    task automatic t_simd4x2();
        logic [31:0] q;
        fill(5, 32'h00002000);
        fill(6, 32'h00300030);
        for (int k = 7; k < 12; k++) fill(k, 32'hC0000000 + k * 16);
        disp(2'd0, 4'h0);
        bus(1'b0, OFF_EMASK, 32'h0, q);
        chk("emask one flow", q, 32'h0000000F);
        run(mk(OP_ADD_D, ES_8, 1, 0, 0, 0, 4'b0111, 8'hE1, 8'h4E), mo(8, 5, 6, 0, 0), 16'h000F);
        disp(2'd1, 4'h0);
        bus(1'b0, OFF_EMASK, 32'h0, q);
        chk("emask two flows", q, 32'h000000FF);
        run(mk(OP_ADD_D, ES_8, 1, 0, 0, 1, 4'b0111, 8'hE1, 8'h4E), mo(10, 5, 6, 0, 0), 16'h00FF);
    endtask

    task automatic t_simd16();
        logic [31:0] q;
        for (int k = 12; k < 20; k++) fill(k, 32'h0001FFF0 + k * 32'h00010100);
        disp(2'd2, 4'b1011);
        bus(1'b0, OFF_EMASK, 32'h0, q);
        chk("emask subspans", q, 32'h0000F0FF);
        run(mk(OP_ADD_W, ES_16, 0, 0, 1, 0, 4'h0, 8'h00, 8'h00), mo(18, 12, 14, 0, 0), 16'hF0FF);
    endtask

    // Every opcode, with the first four execution sizes
    task automatic t_opcodes();
        insn_t ins;
        for (int k = 0; k < 4; k++) begin
            ins = mk(op_t'(k), esize_t'(k), 0, 1, 0, 0, 4'h0, 8'h00, 8'h00);
            ins.vs_zero1 = k[1]; // Second source stride zero in the last two
            run(ins, mo(7'(20 + 2 * k), 12, 12, 3'(k + 1), 3'd5), 16'h0000);
        end
    endtask

    // Cuts a hang short
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        for (int r = 0; r < NUM_REGS; r++)
            for (int d = 0; d < ELEMS; d++) sh[r][d] = 32'h0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_regs();
        t_simd4();
        t_simd4x2();
        t_simd16();
        t_opcodes();
        print_verdict();
    end
endmodule
`default_nettype wire
